// >>> bench/mrs_partner.sv
// reset pin circuit and watchdog expiry source beside the sequencer
`timescale 1ns/10ps
module mrs_partner (
  input wire logic clock,
  input wire logic pin_hold,
  input wire logic wdog_fire,
  output logic ext_reset_pin_n,
  output logic watchdog_timeout
);
  logic fire_ff;
  // idle: pin pulled high, no expiry
  initial begin
    ext_reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    fire_ff = 1'b0;
  end
  // pin follows the hold request; pull-up when released
  always @(posedge clock) begin
    ext_reset_pin_n <= !pin_hold;
  end
  // one-cycle expiry pulse per rising request
  always @(posedge clock) begin
    fire_ff <= wdog_fire;
    watchdog_timeout <= wdog_fire && !fire_ff;
  end
endmodule

// >>> bench/tb_mrs_reset_seq.sv
// self-checking bench of the reset sequencer
`timescale 1ns/10ps
module tb_mrs_reset_seq;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic pin_hold = 1'b0, wdog_fire = 1'b0, halt_enter = 1'b0;
  logic wdog_clear_instr = 1'b0, wake_event = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, chip_reset, pc_sp_reset, watchdog_clear, core_run;
  logic core_halted, timeout_flag, powerdown_flag, irq;
  logic ext_reset_pin_n, watchdog_timeout;
  int err_count = 0, num_checks = 0, n;

  // 25 MHz system clock
  always #20 clock = !clock;

  mrs_partner u_partner (.clock(clock), .pin_hold(pin_hold),
    .wdog_fire(wdog_fire), .ext_reset_pin_n(ext_reset_pin_n),
    .watchdog_timeout(watchdog_timeout));

  mrs_reset_seq DUT (.clock(clock), .srst(srst),
    .ext_reset_pin_n(ext_reset_pin_n), .watchdog_timeout(watchdog_timeout),
    .halt_enter(halt_enter), .wdog_clear_instr(wdog_clear_instr),
    .wake_event(wake_event), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chip_reset(chip_reset), .pc_sp_reset(pc_sp_reset),
    .watchdog_clear(watchdog_clear), .core_run(core_run),
    .core_halted(core_halted), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // classic wishbone single cycle, held until ack is sampled
  task wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20) chk("wb ack", 32'h0, 32'h1);
    @(posedge clock);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // cycles until the core runs, bounded
  task wait_run;
    n = 0;
    while (core_run !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task wdog_pulse;
    @(posedge clock) wdog_fire <= 1'b1;
    @(posedge clock) wdog_fire <= 1'b0;
    @(posedge clock);
    @(negedge clock);
  endtask
  task halt_pulse;
    @(posedge clock) halt_enter <= 1'b1;
    @(posedge clock) halt_enter <= 1'b0;
    @(negedge clock);
  endtask
  task pin_low;
    @(posedge clock) pin_hold <= 1'b1;
    repeat (5) @(negedge clock);
  endtask
  task pin_high;
    @(posedge clock) pin_hold <= 1'b0;
    wait_run;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // power-up: cleared flags, full reset, both delays
  task t_power;
    @(posedge clock) srst <= 1'b0;
    @(negedge clock);
    chk("pu chip_reset", chip_reset, 1'b1);
    chk("pu watchdog_clear", watchdog_clear, 1'b1);
    chk("pu flags", {timeout_flag, powerdown_flag}, 2'b00);
    wait_run;
    chk("pu delay", n >= 1040 && n <= 1045, 1'b1);
    chk("pu released", chip_reset, 1'b0);
    wb_cycle(1'b0, 4'hc, 32'h0);
    chk("ctrl reset", rd[7:0], 8'h10);
    wb_cycle(1'b0, 4'h2, 32'h0);
    chk("unmapped read", rd, 32'h0);
    wb_cycle(1'b0, 4'h0, 32'h0);
    chk("status", rd, 32'h324);
  endtask
  // watchdog in run: full reset, timeout set, interrupt path
  task t_wdog_run;
    wdog_pulse;
    chk("wr chip_reset", {chip_reset, pc_sp_reset}, 2'b11);
    chk("wr flags", {timeout_flag, powerdown_flag}, 2'b10);
    wait_run;
    chk("wr delay", n >= 1038 && n <= 1045, 1'b1);
    wb_cycle(1'b0, 4'h4, 32'h0);
    chk("irq stat", rd[1], 1'b1);
    chk("irq masked", irq, 1'b0);
    wb_cycle(1'b1, 4'h8, 32'hf);
    repeat (2) @(negedge clock);
    chk("irq level", irq, 1'b1);
    wb_cycle(1'b1, 4'h4, 32'hf);
    repeat (2) @(negedge clock);
    chk("irq cleared", irq, 1'b0);
  endtask
  // halt then watchdog: warm reset only, no option load
  task t_warm;
    halt_pulse;
    chk("halt flags", {timeout_flag, powerdown_flag}, 2'b01);
    chk("halted", core_halted, 1'b1);
    wdog_pulse;
    chk("warm resets", {chip_reset, pc_sp_reset}, 2'b01);
    chk("warm flags", {timeout_flag, powerdown_flag}, 2'b11);
    @(negedge clock);
    chk("warm pulse", pc_sp_reset, 1'b0);
    wait_run;
    chk("wake delay", n >= 1020 && n <= 1028, 1'b1);
    wb_cycle(1'b1, 4'h4, 32'hf);
  endtask
  // pin reset in run keeps flags
  task t_pin_run;
    @(posedge clock) wdog_clear_instr <= 1'b1;
    @(posedge clock) wdog_clear_instr <= 1'b0;
    @(negedge clock);
    chk("clr flags", {timeout_flag, powerdown_flag}, 2'b10);
    pin_low;
    chk("pr chip_reset", {chip_reset, watchdog_clear}, 2'b11);
    chk("pr flags", {timeout_flag, powerdown_flag}, 2'b10);
    repeat (1100) @(negedge clock);
    chk("pr held", chip_reset, 1'b1);
    pin_high;
    chk("pr delay", n >= 1040 && n <= 1050, 1'b1);
  endtask
  // pin wake from halt gives 0/1
  task t_pin_halt;
    halt_pulse;
    pin_low;
    chk("ph chip_reset", chip_reset, 1'b1);
    chk("ph flags", {timeout_flag, powerdown_flag}, 2'b01);
    pin_high;
    chk("ph delay", n >= 1040 && n <= 1050, 1'b1);
    // halt again, then a plain wake: start-up delay only
    halt_pulse;
    @(posedge clock) wake_event <= 1'b1;
    @(posedge clock) wake_event <= 1'b0;
    @(negedge clock);
    wait_run;
    chk("wake delay2", n >= 1020 && n <= 1028, 1'b1);
    wb_cycle(1'b0, 4'h4, 32'h0);
    chk("wake irq", rd[3], 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    t_power;
    t_wdog_run;
    t_warm;
    t_pin_run;
    t_pin_halt;
    print_verdict;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    print_verdict;
  end
endmodule

// >>> design/mrs_reset_seq.sv
// reset sequencer: source decode, cause flags, start-up and option delays
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module mrs_reset_seq (
  input wire logic clock,
  input wire logic srst,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic halt_enter,
  input wire logic wdog_clear_instr,
  input wire logic wake_event,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic chip_reset,
  output logic pc_sp_reset,
  output logic watchdog_clear,
  output logic core_run,
  output logic core_halted,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // states in which the chip reset is held
  function automatic logic is_reset_state(input mrs_pkg::mrs_state_t s);
    return (s == mrs_pkg::MRS_PIN) || (s == mrs_pkg::MRS_STARTUP) ||
           (s == mrs_pkg::MRS_OPT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_low;
  mrs_pkg::mrs_state_t state_ff;
  mrs_pkg::mrs_state_t nxt_state;
  logic [10:0] cnt_ff;
  logic [7:0] opt_len_ff;
  logic startup_done;
  logic opt_done;
  logic wdog_run;
  logic wdog_halt;
  logic pin_run;
  logic pin_halt;
  logic wake_done;
  logic [mrs_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [mrs_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [mrs_pkg::IRQ_W-1:0] irq_set;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_data;

  ////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser

  // two flops; only the second is used
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_meta_ff <= 1'b1;
      pin_sync_ff <= 1'b1;
    end else begin
      pin_meta_ff <= ext_reset_pin_n;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign pin_low = ~pin_sync_ff;

  ////////////////////////////////////////////////////////////////////////
  // reset source decode

  // classify each source by the core's mode
  assign pin_run = pin_low && (state_ff != mrs_pkg::MRS_HALT) &&
                   (state_ff != mrs_pkg::MRS_PIN);
  assign pin_halt = pin_low && (state_ff == mrs_pkg::MRS_HALT);
  assign wdog_run = watchdog_timeout && !pin_low &&
                    (state_ff == mrs_pkg::MRS_RUN);
  assign wdog_halt = watchdog_timeout && !pin_low &&
                     (state_ff == mrs_pkg::MRS_HALT);
  assign startup_done = (cnt_ff == mrs_pkg::STARTUP_LAST);
  assign opt_done = (cnt_ff == (11'(opt_len_ff) - 11'h001));
  assign wake_done = (state_ff == mrs_pkg::MRS_WAKE) && startup_done &&
                     !pin_low;

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mrs_pkg::MRS_PIN: begin
        if (!pin_low) begin
          nxt_state = mrs_pkg::MRS_STARTUP;
        end
      end
      mrs_pkg::MRS_STARTUP: begin
        if (pin_low) begin
          nxt_state = mrs_pkg::MRS_PIN;
        end else if (startup_done) begin
          nxt_state = mrs_pkg::MRS_OPT;
        end
      end
      mrs_pkg::MRS_OPT: begin
        if (pin_low) begin
          nxt_state = mrs_pkg::MRS_PIN;
        end else if (opt_done) begin
          nxt_state = mrs_pkg::MRS_RUN;
        end
      end
      mrs_pkg::MRS_RUN: begin
        if (pin_low) begin
          nxt_state = mrs_pkg::MRS_PIN;
        end else if (wdog_run) begin
          nxt_state = mrs_pkg::MRS_STARTUP;
        end else if (halt_enter) begin
          nxt_state = mrs_pkg::MRS_HALT;
        end
      end
      mrs_pkg::MRS_HALT: begin
        if (pin_low) begin
          nxt_state = mrs_pkg::MRS_PIN;
        end else if (wdog_halt || wake_event) begin
          nxt_state = mrs_pkg::MRS_WAKE;
        end
      end
      mrs_pkg::MRS_WAKE: begin
        if (pin_low) begin
          nxt_state = mrs_pkg::MRS_PIN;
        end else if (startup_done) begin
          nxt_state = mrs_pkg::MRS_RUN;
        end
      end
      default: begin
        nxt_state = mrs_pkg::MRS_STARTUP;
      end
    endcase
  end

  // state register; power-up starts the start-up delay
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= mrs_pkg::MRS_STARTUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // delay counter, restarts on every state change
  always_ff @(posedge clock) begin
    if (srst || (nxt_state != state_ff)) begin
      cnt_ff <= 11'h000;
    end else if (state_ff != mrs_pkg::MRS_RUN &&
                 state_ff != mrs_pkg::MRS_HALT) begin
      cnt_ff <= cnt_ff + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to the core units

  // reset controls follow the next state so they come from flops
  always_ff @(posedge clock) begin
    if (srst) begin
      chip_reset <= 1'b1;
      pc_sp_reset <= 1'b1;
      watchdog_clear <= 1'b1;
      core_run <= 1'b0;
      core_halted <= 1'b0;
    end else begin
      chip_reset <= is_reset_state(nxt_state);
      pc_sp_reset <= is_reset_state(nxt_state) || wdog_halt;
      watchdog_clear <= is_reset_state(nxt_state) ||
                        (nxt_state == mrs_pkg::MRS_HALT &&
                         state_ff == mrs_pkg::MRS_RUN);
      core_run <= (nxt_state == mrs_pkg::MRS_RUN);
      core_halted <= (nxt_state == mrs_pkg::MRS_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cause flags

  // timeout flag
  always_ff @(posedge clock) begin
    if (srst) begin
      timeout_flag <= 1'b0;
    end else if (wdog_run || wdog_halt) begin
      timeout_flag <= 1'b1;
    end else if (pin_halt) begin
      timeout_flag <= 1'b0;
    end else if (state_ff == mrs_pkg::MRS_RUN && halt_enter && !pin_low) begin
      timeout_flag <= 1'b0;
    end
  end

  // powerdown flag; pin reset in run leaves it alone
  always_ff @(posedge clock) begin
    if (srst) begin
      powerdown_flag <= 1'b0;
    end else if (pin_halt || wdog_halt) begin
      powerdown_flag <= 1'b1;
    end else if (state_ff == mrs_pkg::MRS_RUN && !pin_low && !wdog_run) begin
      if (halt_enter) begin
        powerdown_flag <= 1'b1;
      end else if (wdog_clear_instr) begin
        powerdown_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;

  // one-cycle answer, dropped in the following cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      mrs_pkg::OFF_STATUS: begin
        rd_data[mrs_pkg::ST_TIMEOUT_BIT] = timeout_flag;
        rd_data[mrs_pkg::ST_POWERDOWN_BIT] = powerdown_flag;
        rd_data[mrs_pkg::ST_RUN_BIT] = core_run;
        rd_data[mrs_pkg::ST_HALT_BIT] = core_halted;
        rd_data[mrs_pkg::ST_CHIPRST_BIT] = chip_reset;
        rd_data[mrs_pkg::ST_PIN_BIT] = pin_sync_ff;
        rd_data[mrs_pkg::ST_STATE_LSB +: 3] = state_ff;
      end
      mrs_pkg::OFF_IRQ_STAT: begin
        rd_data[mrs_pkg::IRQ_W-1:0] = irq_stat_ff;
      end
      mrs_pkg::OFF_IRQ_MASK: begin
        rd_data[mrs_pkg::IRQ_W-1:0] = irq_mask_ff;
      end
      mrs_pkg::OFF_CTRL: begin
        rd_data[7:0] = opt_len_ff;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // read data register
  always_ff @(posedge clock) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  // option-load length, zero is raised to one
  always_ff @(posedge clock) begin
    if (srst) begin
      opt_len_ff <= mrs_pkg::OPT_LEN_RST;
    end else if (bus_wr && wb_adr_i == mrs_pkg::OFF_CTRL && wb_sel_i[0]) begin
      if (wb_dat_i[7:0] == 8'h00) begin
        opt_len_ff <= mrs_pkg::OPT_LEN_MIN;
      end else begin
        opt_len_ff <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  // events: pin reset, watchdog reset, warm reset, wake complete
  always_comb begin
    irq_set = '0;
    irq_set[mrs_pkg::IRQ_PIN_BIT] = pin_run || pin_halt;
    irq_set[mrs_pkg::IRQ_WDOG_BIT] = wdog_run;
    irq_set[mrs_pkg::IRQ_WARM_BIT] = wdog_halt;
    irq_set[mrs_pkg::IRQ_WAKE_BIT] = wake_done;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_stat_ff <= mrs_pkg::IRQ_RST;
    end else if (bus_wr && wb_adr_i == mrs_pkg::OFF_IRQ_STAT &&
                 wb_sel_i[0]) begin
      irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[mrs_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_set;
    end
  end

  // mask register
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_mask_ff <= mrs_pkg::IRQ_RST;
    end else if (bus_wr && wb_adr_i == mrs_pkg::OFF_IRQ_MASK &&
                 wb_sel_i[0]) begin
      irq_mask_ff <= wb_dat_i[mrs_pkg::IRQ_W-1:0];
    end
  end

  // level interrupt from flops
  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_wdog_run_reset: assert property (@(posedge clock) disable iff (srst)
    wdog_run |=> chip_reset && state_ff == mrs_pkg::MRS_STARTUP)
    else $error("watchdog expiry in run did not start chip reset");

  a_warm_reset_only: assert property (@(posedge clock) disable iff (srst)
    wdog_halt |=> pc_sp_reset && !chip_reset &&
                 state_ff == mrs_pkg::MRS_WAKE)
    else $error("warm reset wrong");

  a_pin_halt_flags: assert property (@(posedge clock) disable iff (srst)
    pin_halt |=> !timeout_flag && powerdown_flag)
    else $error("pin wake from halt flags wrong");

  a_pin_run_flags: assert property (@(posedge clock) disable iff (srst)
    pin_run && !watchdog_timeout |=>
      $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("pin reset in run changed flags");

  a_wdog_flags: assert property (@(posedge clock) disable iff (srst)
    wdog_run |=> timeout_flag && $stable(powerdown_flag))
    else $error("watchdog reset flags wrong");

  a_startup_length: assert property (@(posedge clock) disable iff (srst)
    (state_ff == mrs_pkg::MRS_STARTUP || state_ff == mrs_pkg::MRS_WAKE) &&
    nxt_state != state_ff && !pin_low |-> cnt_ff == 11'h3ff)
    else $error("start-up delay not 1024 cycles");

  a_opt_follows: assert property (@(posedge clock) disable iff (srst)
    state_ff == mrs_pkg::MRS_STARTUP && startup_done && !pin_low
    |=> state_ff == mrs_pkg::MRS_OPT && chip_reset)
    else $error("option-load delay skipped");

  a_chip_units: assert property (@(posedge clock) disable iff (srst)
    chip_reset |-> pc_sp_reset && watchdog_clear && !core_run)
    else $error("chip reset incomplete");

  a_halt_flags: assert property (@(posedge clock) disable iff (srst)
    state_ff == mrs_pkg::MRS_RUN && halt_enter && !pin_low && !wdog_run
    |=> powerdown_flag && !timeout_flag && core_halted)
    else $error("halt entry flags wrong");

  a_run_after_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(core_run) |-> $past(state_ff) == mrs_pkg::MRS_OPT ||
                        $past(state_ff) == mrs_pkg::MRS_WAKE)
    else $error("core released early");

  a_pin_sources: assert property (@(posedge clock) disable iff (srst)
    pin_low |=> state_ff == mrs_pkg::MRS_PIN && chip_reset)
    else $error("pin reset not taken");

endmodule

// >>> pkg/mrs_pkg.sv
// constants, states and register map of the reset sequencer
// Behaviour
// - accept pin reset in run, pin reset in halt, watchdog expiry in run
// - watchdog expiry in halt clears only pc and stack pointer
// - power-up clears both flags; pin reset keeps them; pin wake gives 0/1
// - watchdog expiry in run sets timeout flag; watchdog wake leaves both 1
// - every reset and every halt wake inserts 1024 clock start-up delay
// - power-up, watchdog reset and pin reset add an option-load delay
// - chip reset clears pc, interrupts, timer, ports, stack, watchdog
// - halt sets powerdown, clears timeout; watchdog-clear, power-up clear it
// - watchdog expiry runs full reset in run, warm reset in halt
package mrs_pkg;

  // start-up timer length in system clocks
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

  // option-load delay, reset value of the control field
  localparam logic [7:0] OPT_LEN_RST = 8'h10;
  localparam logic [7:0] OPT_LEN_MIN = 8'h01;

  // register byte offsets
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hc;

  // status register fields
  localparam int unsigned ST_TIMEOUT_BIT = 0;
  localparam int unsigned ST_POWERDOWN_BIT = 1;
  localparam int unsigned ST_RUN_BIT = 2;
  localparam int unsigned ST_HALT_BIT = 3;
  localparam int unsigned ST_CHIPRST_BIT = 4;
  localparam int unsigned ST_PIN_BIT = 5;
  localparam int unsigned ST_STATE_LSB = 8;

  // interrupt status and mask fields
  localparam int unsigned IRQ_PIN_BIT = 0;
  localparam int unsigned IRQ_WDOG_BIT = 1;
  localparam int unsigned IRQ_WARM_BIT = 2;
  localparam int unsigned IRQ_WAKE_BIT = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // sequencer states, gray along reset path startup -> opt -> run -> halt
  typedef enum logic [2:0] {
    MRS_STARTUP = 3'b000,
    MRS_OPT = 3'b001,
    MRS_RUN = 3'b011,
    MRS_HALT = 3'b010,
    MRS_WAKE = 3'b110,
    MRS_PIN = 3'b111,
    MRS_SPARE = 3'b101
  } mrs_state_t;

endpackage
